// ==== design/sgb_pkg.sv ====
package sgb_pkg;
  // ==========================================
  // timebase
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam int unsigned PCT_FULL = 100;

  // ==========================================
  // register indices, byte address is four times the index
  localparam logic [15:0] IDX_OV_THR = 16'h2034;
  localparam logic [15:0] IDX_UV_THR = 16'h2035;
  localparam logic [15:0] IDX_IDLE_TIME = 16'h2036;
  localparam logic [15:0] IDX_RED_SET = 16'h2037;
  localparam logic [15:0] IDX_BRK_COUNT = 16'h2040;
  localparam logic [15:0] IDX_BRK_CLOSE = 16'h2041;
  localparam logic [15:0] IDX_PWR_OFF = 16'h2042;
  localparam logic [15:0] IDX_BRK_OPEN = 16'h2043;
  localparam logic [15:0] IDX_START_DLY = 16'h2044;
  localparam logic [15:0] IDX_PWM_FREQ = 16'h2045;
  localparam logic [15:0] IDX_PWM_DUTY = 16'h2046;
  localparam logic [15:0] IDX_MOTOR_CFG = 16'h2050;
  localparam logic [15:0] IDX_STATUS = 16'h2051;
  localparam logic [15:0] IDX_IRQ_STAT = 16'h2052;
  localparam logic [15:0] IDX_IRQ_EN = 16'h2053;
  localparam logic [15:0] IDX_IRQ_CLR = 16'h2054;
  localparam logic [15:0] IDX_RATED_CUR = 16'h2055;

  // ==========================================
  // reset values
  localparam logic [31:0] RST_OV_THR = 32'h0000EF3D;
  localparam logic [31:0] RST_UV_THR = 32'h00002710;
  localparam logic [31:0] RST_IDLE_TIME = 32'h000003E8;
  localparam logic [31:0] RST_RED_SET = 32'h0FFFFFCE;
  localparam logic [31:0] RST_BRK_COUNT = 32'h00000006;
  localparam logic [31:0] RST_BRK_DLY = 32'h000003E8;
  localparam logic [31:0] RST_START_DLY = 32'h00000000;
  localparam logic [31:0] RST_PWM = 32'h00000000;
  localparam logic [31:0] RST_RATED_CUR = 32'h00000258;

  // ==========================================
  // limits and hysteresis
  localparam logic [32:0] OV_HYST_MV = 33'h0000007D0;
  localparam logic [32:0] UV_HYST_MV = 33'h0000005DC;
  localparam logic [31:0] PWM_FREQ_MAX = 32'h000007D0;
  localparam logic [31:0] PWM_DUTY_MIN = 32'h00000002;
  localparam logic [31:0] PWM_DUTY_MAX = 32'h00000064;
  localparam logic signed [31:0] RED_PCT_MIN = -32'sd100;

  // ==========================================
  // motor configuration bits
  localparam int unsigned CFG_ENABLE_BIT = 0;
  localparam int unsigned CFG_CLOSED_LOOP_BIT = 1;
  localparam int unsigned CFG_REDUCE_BIT = 3;

  // ==========================================
  // interrupt bits
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_OV = 0;
  localparam int unsigned IRQ_UV = 1;
  localparam int unsigned IRQ_OP_EN = 2;
  localparam int unsigned IRQ_BRAKED = 3;

  typedef enum logic [5:0] {
    ST_OFF = 6'b000001,
    ST_POWER_UP = 6'b000010,
    ST_RELEASED = 6'b000100,
    ST_ENABLED = 6'b001000,
    ST_CLOSE_WAIT = 6'b010000,
    ST_POWER_DOWN = 6'b100000
  } sgb_state_t;

  typedef struct packed {
    logic motor_power_on;
    logic brake_release;
    logic operation_enabled;
  } sgb_drive_t;

  typedef struct packed {
    logic overvoltage;
    logic undervoltage;
    logic reduction_active;
  } sgb_fault_t;
endpackage

// ==== design/sgb_supply_guard_and_brake_sequencer.sv ====
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - supply above upper threshold stops motor, flags
// - overvoltage clears below threshold minus 2 V
// - supply below lower threshold stops motor, flags
// - undervoltage clears above threshold plus 1.5 V
// - reduction only after standstill idle time elapses
// - reduction needs open loop, reduce bit, standstill
// - small non-negative setting is reduced current
// - setting -1..-100 scales rated current percent
// - wait close delay after standstill, engage brake
// - wait power-off delay after brake, cut current
// - power on first, wait, then release brake
// - wait start delay, then operation enabled
// - brake PWM at programmed hertz, 0..2000
// - brake duty percent, 0 or 2..100
module sgb_supply_guard_and_brake_sequencer #(
  parameter int unsigned TICK_CYCLES = sgb_pkg::MS_CYCLES,
  parameter int unsigned PWM_CLK_HZ = sgb_pkg::CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] supply_mv,
  input wire logic motor_standstill,
  output sgb_pkg::sgb_drive_t drive,
  output sgb_pkg::sgb_fault_t fault,
  output logic [31:0] reduced_current_ma,
  output logic brake_pwm,
  output logic irq
);
  import sgb_pkg::*;

  // ==========================================
  // parameter checks, refused at elaboration
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end
  // the accumulator needs two clocks per pwm period at the top frequency
  if (PWM_CLK_HZ < 2 * int'(PWM_FREQ_MAX)) begin : g_bad_pwm_clk
    $error("PWM_CLK_HZ too low");
  end
  if (PWM_CLK_HZ / PCT_FULL == 0) begin : g_bad_duty_clk
    $error("PWM_CLK_HZ too low for duty");
  end

  // ==========================================
  // registers
  logic [31:0] ov_thr_q, uv_thr_q, idle_time_q, red_set_q;
  logic [31:0] brk_close_q, pwr_off_q, brk_open_q, start_dly_q;
  logic [31:0] pwm_freq_q, pwm_duty_q, motor_cfg_q, rated_cur_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_en_q, irq_set;
  logic ov_q, uv_q;
  sgb_state_t state_q, state_d;
  logic [31:0] seq_ms_q, idle_ms_q, tick_cnt_q, phase_q;
  logic ms_tick;

  // ==========================================
  // apb decode
  logic wr_acc, rd_setup, addr_ok, wr_bad;
  logic [15:0] idx;
  assign idx = {2'b00, paddr[15:2]};
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;

  always_comb begin
    case (idx)
      IDX_OV_THR, IDX_UV_THR, IDX_IDLE_TIME, IDX_RED_SET, IDX_BRK_COUNT, IDX_BRK_CLOSE,
      IDX_PWR_OFF, IDX_BRK_OPEN, IDX_START_DLY, IDX_PWM_FREQ, IDX_PWM_DUTY, IDX_MOTOR_CFG,
      IDX_STATUS, IDX_IRQ_STAT, IDX_IRQ_EN, IDX_IRQ_CLR, IDX_RATED_CUR: addr_ok = (paddr[1:0] == 2'b00);
      default: addr_ok = 1'b0;
    endcase
  end

  // out-of-range pwm frequency and duty settings and writes to read-only words are refused
  always_comb begin
    wr_bad = !addr_ok;
    case (idx)
      IDX_PWM_FREQ: wr_bad = !addr_ok || (pwdata > PWM_FREQ_MAX);
      IDX_PWM_DUTY: wr_bad = !addr_ok
                             || ((pwdata != 32'h00000000) && ((pwdata < PWM_DUTY_MIN) || (pwdata > PWM_DUTY_MAX)));
      IDX_BRK_COUNT, IDX_STATUS, IDX_IRQ_STAT: wr_bad = 1'b1;
      default: wr_bad = !addr_ok;
    endcase
  end

  assign pslverr = psel && penable && (pwrite ? wr_bad : !addr_ok);

  logic wr_ok;
  assign wr_ok = wr_acc && !wr_bad;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_thr_q <= RST_OV_THR;
      uv_thr_q <= RST_UV_THR;
      idle_time_q <= RST_IDLE_TIME;
      red_set_q <= RST_RED_SET;
      brk_close_q <= RST_BRK_DLY;
      pwr_off_q <= RST_BRK_DLY;
      brk_open_q <= RST_BRK_DLY;
      start_dly_q <= RST_START_DLY;
      pwm_freq_q <= RST_PWM;
      pwm_duty_q <= RST_PWM;
      motor_cfg_q <= 32'h00000000;
      rated_cur_q <= RST_RATED_CUR;
      irq_en_q <= '0;
    end else if (wr_ok) begin
      case (idx)
        IDX_OV_THR: ov_thr_q <= pwdata;
        IDX_UV_THR: uv_thr_q <= pwdata;
        IDX_IDLE_TIME: idle_time_q <= pwdata;
        IDX_RED_SET: red_set_q <= pwdata;
        IDX_BRK_CLOSE: brk_close_q <= pwdata;
        IDX_PWR_OFF: pwr_off_q <= pwdata;
        IDX_BRK_OPEN: brk_open_q <= pwdata;
        IDX_START_DLY: start_dly_q <= pwdata;
        IDX_PWM_FREQ: pwm_freq_q <= pwdata;
        IDX_PWM_DUTY: pwm_duty_q <= pwdata;
        IDX_MOTOR_CFG: motor_cfg_q <= pwdata;
        IDX_IRQ_EN: irq_en_q <= pwdata[IRQ_W-1:0];
        IDX_RATED_CUR: rated_cur_q <= pwdata;
        default: ;
      endcase
    end
  end

  // read data is captured in the setup cycle so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (idx)
        IDX_OV_THR: prdata <= ov_thr_q;
        IDX_UV_THR: prdata <= uv_thr_q;
        IDX_IDLE_TIME: prdata <= idle_time_q;
        IDX_RED_SET: prdata <= red_set_q;
        IDX_BRK_COUNT: prdata <= RST_BRK_COUNT;
        IDX_BRK_CLOSE: prdata <= brk_close_q;
        IDX_PWR_OFF: prdata <= pwr_off_q;
        IDX_BRK_OPEN: prdata <= brk_open_q;
        IDX_START_DLY: prdata <= start_dly_q;
        IDX_PWM_FREQ: prdata <= pwm_freq_q;
        IDX_PWM_DUTY: prdata <= pwm_duty_q;
        IDX_MOTOR_CFG: prdata <= motor_cfg_q;
        IDX_STATUS: prdata <= {23'h000000, state_q, fault.reduction_active, uv_q, ov_q};
        IDX_IRQ_STAT: prdata <= {{(32-IRQ_W){1'b0}}, irq_stat_q};
        IDX_IRQ_EN: prdata <= {{(32-IRQ_W){1'b0}}, irq_en_q};
        IDX_RATED_CUR: prdata <= rated_cur_q;
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================
  // millisecond tick
  // common ms tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h00000000;
    end else if (ms_tick) begin
      tick_cnt_q <= 32'h00000000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
    end
  end
  assign ms_tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

  // ==========================================
  // supply guard
  logic [32:0] v_ext, ov_ext, uv_ext;
  assign v_ext = {1'b0, supply_mv};
  assign ov_ext = {1'b0, ov_thr_q};
  assign uv_ext = {1'b0, uv_thr_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_q <= 1'b0;
    end else if (v_ext > ov_ext) begin
      ov_q <= 1'b1;
    end else if (v_ext + OV_HYST_MV < ov_ext) begin
      ov_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_q <= 1'b0;
    end else if (v_ext < uv_ext) begin
      uv_q <= 1'b1;
    end else if (v_ext > uv_ext + UV_HYST_MV) begin
      uv_q <= 1'b0;
    end
  end

  logic supply_fault;
  assign supply_fault = ov_q || uv_q;

  // ==========================================
  // brake and power sequencer
  logic enable_req;
  assign enable_req = motor_cfg_q[CFG_ENABLE_BIT] && !supply_fault;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (enable_req) state_d = ST_POWER_UP;
      end
      ST_POWER_UP: begin
        if (!enable_req) state_d = ST_OFF;
        else if (seq_ms_q >= brk_open_q) state_d = ST_RELEASED;
      end
      ST_RELEASED: begin
        if (!enable_req) state_d = ST_CLOSE_WAIT;
        else if (seq_ms_q >= start_dly_q) state_d = ST_ENABLED;
      end
      ST_ENABLED: begin
        if (!enable_req) state_d = ST_CLOSE_WAIT;
      end
      ST_CLOSE_WAIT: begin
        if (motor_standstill && seq_ms_q >= brk_close_q) state_d = ST_POWER_DOWN;
      end
      ST_POWER_DOWN: begin
        if (seq_ms_q >= pwr_off_q) state_d = ST_OFF;
      end
      default: state_d = ST_OFF;
    endcase
    // supply fault forces motor off at once
    if (supply_fault) state_d = ST_OFF;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // delay count restarts on any state change or on loss of standstill in close wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_ms_q <= 32'h00000000;
    end else if (state_d != state_q || (state_q == ST_CLOSE_WAIT && !motor_standstill)) begin
      seq_ms_q <= 32'h00000000;
    end else if (ms_tick && seq_ms_q != 32'hFFFFFFFF) begin
      seq_ms_q <= seq_ms_q + 32'h00000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive <= '0;
    end else begin
      drive.motor_power_on <= (state_d != ST_OFF);
      drive.brake_release <= (state_d == ST_RELEASED) || (state_d == ST_ENABLED) || (state_d == ST_CLOSE_WAIT);
      drive.operation_enabled <= (state_d == ST_ENABLED);
    end
  end

  // ==========================================
  // standstill current reduction
  // idle count in ms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_ms_q <= 32'h00000000;
    end else if (!motor_standstill) begin
      idle_ms_q <= 32'h00000000;
    end else if (ms_tick && idle_ms_q != 32'hFFFFFFFF) begin
      idle_ms_q <= idle_ms_q + 32'h00000001;
    end
  end

  logic signed [31:0] red_s;
  logic [31:0] red_target;
  logic [39:0] red_prod;
  assign red_s = signed'(red_set_q);
  assign red_prod = 40'(rated_cur_q) * 40'(red_s + 32'sd100);

  // an out-of-range setting leaves the rated current in place
  always_comb begin
    red_target = rated_cur_q;
    if (red_s >= 0 && red_set_q < rated_cur_q) begin
      red_target = red_set_q;
    end else if (red_s < 0 && red_s >= RED_PCT_MIN) begin
      red_target = 32'(red_prod / 40'(PCT_FULL));
    end
  end

  logic reduce_on;
  assign reduce_on = !motor_cfg_q[CFG_CLOSED_LOOP_BIT] && motor_cfg_q[CFG_REDUCE_BIT] && motor_standstill
                     && (idle_ms_q >= idle_time_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault <= '0;
      reduced_current_ma <= 32'h00000000;
    end else begin
      fault.overvoltage <= ov_q;
      fault.undervoltage <= uv_q;
      fault.reduction_active <= reduce_on;
      reduced_current_ma <= reduce_on ? red_target : rated_cur_q;
    end
  end

  // ==========================================
  // brake pwm, phase accumulator avoids a divider by the frequency
  logic [32:0] phase_next;
  logic [31:0] duty_level;
  assign phase_next = {1'b0, phase_q} + {1'b0, pwm_freq_q};
  assign duty_level = 32'(PWM_CLK_HZ / PCT_FULL) * pwm_duty_q;

  // phase advances by frequency per clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= 32'h00000000;
    end else if (phase_next >= 33'(PWM_CLK_HZ)) begin
      phase_q <= 32'(phase_next - 33'(PWM_CLK_HZ));
    end else begin
      phase_q <= phase_next[31:0];
    end
  end

  // zero frequency or zero duty drives the brake coil at a steady level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_pwm <= 1'b0;
    end else if (pwm_freq_q == 32'h00000000 || pwm_duty_q == 32'h00000000) begin
      brake_pwm <= drive.brake_release;
    end else begin
      brake_pwm <= drive.brake_release && (phase_q < duty_level);
    end
  end

  // ==========================================
  // interrupts
  assign irq_set[IRQ_OV] = ov_q && !fault.overvoltage;
  assign irq_set[IRQ_UV] = uv_q && !fault.undervoltage;
  // drive follows state_d, so the entry is seen on the state pair, not on the output
  assign irq_set[IRQ_OP_EN] = (state_d == ST_ENABLED) && (state_q != ST_ENABLED);
  assign irq_set[IRQ_BRAKED] = state_q == ST_POWER_DOWN && state_d == ST_OFF;

  // a set in the same cycle as its clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr_ok && idx == IDX_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0)) | irq_set;
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);
endmodule

// ==== bench/sgb_properties.sv ====
`timescale 1ns/1ps
module sgb_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic motor_standstill,
  input wire sgb_pkg::sgb_drive_t drive,
  input wire sgb_pkg::sgb_fault_t fault,
  input wire logic brake_pwm
);
  import sgb_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // assertions
  a_fault_stops_drive: assert property ((fault.overvoltage || fault.undervoltage) |-> drive == '0)
    else $error("drive active during supply fault");
  a_brake_needs_power: assert property (drive.brake_release |-> drive.motor_power_on)
    else $error("brake released without motor power");
  a_op_needs_brake: assert property (drive.operation_enabled |-> drive.brake_release)
    else $error("operation enabled with brake engaged");
  a_power_before_release: assert property ($rose(drive.brake_release) |-> $past(drive.motor_power_on))
    else $error("brake released in same cycle as power on");
  a_release_before_op: assert property ($rose(drive.operation_enabled) |-> $past(drive.brake_release))
    else $error("operation enabled before brake release");
  a_brake_before_cut: assert property ($fell(drive.motor_power_on) && !fault.overvoltage && !fault.undervoltage
    |-> !$past(drive.brake_release))
    else $error("power cut while brake open");
  a_engage_powered: assert property ($fell(drive.brake_release) && !fault.overvoltage
    && !fault.undervoltage |-> drive.motor_power_on)
    else $error("brake engaged without motor power");
  a_pwm_quiet: assert property (!drive.brake_release && !$past(drive.brake_release) |-> !brake_pwm)
    else $error("brake pwm active while brake engaged");
  a_reduce_off_moving: assert property ($fell(motor_standstill) |-> ##3 !fault.reduction_active)
    else $error("reduction kept while moving");
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  c_op_enabled: cover property ($rose(drive.operation_enabled));
  c_overvoltage: cover property ($rose(fault.overvoltage));
  c_reduction: cover property ($rose(fault.reduction_active));
endmodule
bind sgb_supply_guard_and_brake_sequencer sgb_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .motor_standstill(motor_standstill), .drive(drive),
  .fault(fault), .brake_pwm(brake_pwm));

// ==== bench/sgb_plant.sv ====
`timescale 1ns/1ps
module sgb_plant (
  input wire logic pclk,
  input wire sgb_pkg::sgb_drive_t drive,
  input wire logic move_req,
  input wire logic [31:0] supply_set,
  output logic [31:0] supply_mv,
  output logic motor_standstill
);
  import sgb_pkg::*;
  logic [1:0] run_q;
  // ==========================================
  // supply settles a cycle late; the rotor only turns while operation is enabled
  initial begin
    supply_mv = 32'h00005DC0;
    motor_standstill = 1'b1;
    run_q = 2'b00;
  end
  always @(posedge pclk) begin
    supply_mv <= supply_set;
    run_q <= {run_q[0], move_req & drive.operation_enabled};
    motor_standstill <= ~|run_q;
  end
endmodule

// ==== bench/sgb_supply_guard_and_brake_sequencer_tb.sv ====
`timescale 1ns/1ps
module sgb_supply_guard_and_brake_sequencer_tb;
  import sgb_pkg::*;
  localparam int TK = 10;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, move_req = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, supply_set = 32'h00005DC0, prdata, red_ma, sup;
  logic pready, pslverr, brake_pwm, irq, still, pwm_prev;
  logic [33:0] e;
  logic [33:0] exp_q[$];
  sgb_drive_t drive;
  sgb_fault_t fault;
  int n_errors = 0, checked = 0, seed = 75, n, r;
  sgb_supply_guard_and_brake_sequencer #(.TICK_CYCLES(TK), .PWM_CLK_HZ(4000)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_mv(sup), .motor_standstill(still),
    .drive(drive), .fault(fault), .reduced_current_ma(red_ma), .brake_pwm(brake_pwm), .irq(irq));
  sgb_plant plant (.pclk(pclk), .drive(drive), .move_req(move_req), .supply_set(supply_set),
    .supply_mv(sup), .motor_standstill(still));
  initial forever #2.5 pclk = ~pclk;
  // ==========================================
  // checking
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, w, got, exp);
    end
  endtask
  task automatic chk_rng(input int c, input int lo, input int hi, input string w);
    checked++;
    if (c < lo || c > hi) begin
      n_errors++;
      $display("wrong value at %0t: %s took %0d cycles", $time, w, c);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk(32'(pslverr), 32'(e[32]), "slverr");
      if (e[33]) chk(prdata, e[31:0], "read");
    end
  end
  // ==========================================
  // stimulus
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d, input logic er,
    input logic [31:0] x);
    @(posedge pclk);
    exp_q.push_back({~wr, er, x});
    psel <= 1;
    pwrite <= wr;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wait_bit(input int b, input logic v, output int c);
    c = 0;
    while (drive[b] !== v && c < 2000) begin
      @(posedge pclk);
      c++;
    end
  endtask
  task automatic set_sup(input logic [31:0] v);
    supply_set <= v;
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    apb(0, IDX_OV_THR, 0, 0, RST_OV_THR);
    apb(0, IDX_UV_THR, 0, 0, RST_UV_THR);
    apb(0, IDX_IDLE_TIME, 0, 0, RST_IDLE_TIME);
    apb(0, IDX_RED_SET, 0, 0, RST_RED_SET);
    apb(0, IDX_BRK_COUNT, 0, 0, RST_BRK_COUNT);
    apb(0, IDX_BRK_CLOSE, 0, 0, RST_BRK_DLY);
    apb(0, IDX_PWR_OFF, 0, 0, RST_BRK_DLY);
    apb(0, IDX_BRK_OPEN, 0, 0, RST_BRK_DLY);
    apb(0, IDX_START_DLY, 0, 0, RST_START_DLY);
    apb(1, IDX_BRK_COUNT, 7, 1, 0);
    apb(0, 16'h2060, 0, 1, 0);
    apb(1, IDX_PWM_FREQ, 32'h000007D1, 1, 0);
    apb(1, IDX_PWM_DUTY, 1, 1, 0);
    apb(1, IDX_PWM_DUTY, 32'h00000065, 1, 0);
    apb(0, IDX_PWM_FREQ, 0, 0, RST_PWM);
    apb(1, IDX_PWM_FREQ, 32'h00000190, 0, 0);
    apb(1, IDX_PWM_DUTY, 32'h0000001E, 0, 0);
    apb(1, IDX_BRK_OPEN, 3, 0, 0);
    apb(1, IDX_START_DLY, 2, 0, 0);
    apb(1, IDX_BRK_CLOSE, 2, 0, 0);
    apb(1, IDX_PWR_OFF, 1, 0, 0);
    apb(1, IDX_IDLE_TIME, 3, 0, 0);
    apb(1, IDX_RED_SET, 32'hFFFFFFCE, 0, 0);
    apb(1, IDX_IRQ_EN, 32'h0000000F, 0, 0);
    apb(1, IDX_MOTOR_CFG, 32'h00000009, 0, 0);
    wait_bit(2, 1, n);
    chk_rng(n, 0, 6, "power on");
    wait_bit(1, 1, n);
    chk_rng(n, 2 * TK, 4 * TK + 4, "open delay");
    wait_bit(0, 1, n);
    chk_rng(n, TK, 3 * TK + 4, "start delay");
    repeat (2) @(posedge pclk);
    chk(32'(irq), 1, "irq op");
    n = 0;
    r = 0;
    pwm_prev = brake_pwm;
    repeat (100) begin
      @(posedge pclk);
      n += int'(brake_pwm);
      r += int'(brake_pwm && !pwm_prev);
      pwm_prev = brake_pwm;
    end
    chk(n, 30, "pwm duty");
    chk(r, 10, "pwm periods");
    apb(1, IDX_IRQ_CLR, 32'h0000000F, 0, 0);
    apb(0, IDX_IRQ_STAT, 0, 0, 0);
    chk(32'(irq), 0, "irq cleared");
    move_req <= 1;
    repeat (10) @(posedge pclk);
    move_req <= 0;
    while (still !== 1'b1) @(posedge pclk);
    n = 0;
    while (fault.reduction_active !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk_rng(n, 2 * TK, 4 * TK + 6, "idle time");
    repeat (3) @(posedge pclk);
    chk(red_ma, 32'h0000012C, "reduced -50");
    move_req <= 1;
    repeat (10) @(posedge pclk);
    apb(1, IDX_MOTOR_CFG, 32'h00000008, 0, 0);
    while (still !== 1'b1) @(posedge pclk);
    wait_bit(1, 0, n);
    chk_rng(n, TK, 3 * TK + 4, "close delay");
    wait_bit(2, 0, n);
    chk_rng(n, 1, 2 * TK + 4, "power off delay");
    move_req <= 0;
    repeat (2) @(posedge pclk);
    chk(32'(irq), 1, "irq braked");
    apb(0, IDX_IRQ_STAT, 0, 0, 32'h00000008);
    apb(1, IDX_RED_SET, 32'hFFFFFF9C, 0, 0);
    repeat (3) @(posedge pclk);
    chk(red_ma, 0, "reduced -100");
    r = {$random(seed)} % 600;
    apb(1, IDX_RED_SET, r, 0, 0);
    repeat (3) @(posedge pclk);
    chk(red_ma, r, "reduced direct");
    apb(1, IDX_RED_SET, RST_RATED_CUR, 0, 0);
    repeat (3) @(posedge pclk);
    chk(red_ma, RST_RATED_CUR, "setting at rated");
    apb(1, IDX_MOTOR_CFG, 32'h0000000B, 0, 0);
    repeat (3) @(posedge pclk);
    chk(32'(fault.reduction_active), 0, "closed loop");
    wait_bit(0, 1, n);
    apb(1, IDX_IRQ_CLR, 32'h0000000F, 0, 0);
    apb(1, IDX_IRQ_EN, 1, 0, 0);
    set_sup(32'h0000EF3E);
    chk(32'(fault.overvoltage), 1, "ov set");
    chk(32'(drive), 0, "ov drive off");
    chk(32'(irq), 1, "irq ov");
    set_sup(32'h0000E76D);
    chk(32'(fault.overvoltage), 1, "ov hold");
    set_sup(32'h0000E76C);
    chk(32'(fault.overvoltage), 0, "ov clear");
    wait_bit(1, 1, n);
    chk_rng(n, 2 * TK, 4 * TK + 8, "restart open");
    apb(1, IDX_IRQ_CLR, 1, 0, 0);
    set_sup(32'h0000270F);
    chk(32'(fault.undervoltage), 1, "uv set");
    chk(32'(drive), 0, "uv drive off");
    chk(32'(irq), 0, "irq masked");
    set_sup(32'h00002CEC);
    chk(32'(fault.undervoltage), 1, "uv hold");
    set_sup(32'h00002CED);
    chk(32'(fault.undervoltage), 0, "uv clear");
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    report_and_stop();
  end
endmodule
